// *** include/ledd_pkg.sv ***
/*
  Shared constants for the LED sink driver control logic: channel and
  shift register sizes, counter limits, sample point and group delay.
  Assumes the core runs on a 20 MHz PWM count clock (50 ns period).
*/
// Overview of operation
// RL1: Seventeen-bit status word is readable only in grayscale mode.
// RL2: First shift edge after latch loads status into top 17 bits.
// RL3: Normal mode shifts status out one bit per rising shift edge.
// RL4: Open-LED flags update on the 33rd count edge, held otherwise.
// RL5: Flag is one for an on channel with low sink voltage.
// RL6: Controller programs grayscale of at least 21h per channel.
// RL7: Over-temperature flag follows die temperature sense.
// RL8: Over-temperature flag holds until first falling edge after latch.
// RL9: Error output low on overtemp, or open LED while unblanked.
// RL10: Error output is open drain, only ever pulls low.
// RL11: Channels grouped by index modulo four, staggered on and off.
// RL12: Blank high forces channels off and clears the counter.
// RL13: Short blank low gives the shorter of grayscale and blank time.
// RL14: Mode low uses 192-bit grayscale, mode high 96-bit trim.
// RL15: Controller keeps latch strobe low while changing mode.
// RL16: Serial out feeds next device serial in; clock and latch shared.
// RL17: Controller keeps both clocks above their minimum rates.
// RL18: Extended mode counts latch pulses under blank to pick a half.
// RL19: Controller sends one or two selecting pulses before shifting.
// RL20: Extended mode drives serial out on falling shift edges.
// RL21: Extended mode returns status only while shifting the upper half.
// RL22: Extended behaviour only with mode low; trim mode unchanged.
// RL23: Data shifts in MSB first; latch copies into selected latch.
// RL24: Channel on while counter within grayscale; counter stops at FFFh.
// RL25: Status word holds overtemp at bit 16, open flags 15 to 0.
// RL26: Group delay is one fixed constant between consecutive groups.
// RL27: Controller keeps blank high until data are latched.
package ledd_pkg;
  localparam int NCH = 16;
  localparam int GS_W = 12;
  localparam int GS_LEN = 192;
  localparam int DC_LEN = 96;
  localparam int HALF_LEN = 96;
  localparam int STAT_W = 17;
  localparam int OT_POS = 16;
  localparam int NGRP = 4;
  localparam int CLK_NS = 50;
  localparam int GRP_DLY_NS = 50;
  localparam int GRP_DLY = (GRP_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int TAPS = (NGRP - 1) * GRP_DLY + 1;
  localparam logic [11:0] CNT_RST = 12'h000;
  localparam logic [11:0] CNT_MAX = 12'hfff;
  localparam logic [11:0] LOD_EDGE = 12'h021;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [1:0] SEL_HIGH = 2'h2;
endpackage

// *** include/ledd_xfer_if.sv ***
/*
  Signals between the core domain and the shift clock domain.
  Words from the core are quasi-static: they change only around a latch
  strobe or a mode or select pin change, while the controller holds the shift clock still. sr_data and the two toggles move on shift edges.
*/
`timescale 1ns/10ps
interface ledd_xfer_if;
  import ledd_pkg::*;
  logic [GS_LEN-1:0] sr_data;
  logic seen_tgl;
  logic fall_tgl;
  logic arm_tgl;
  logic half_sel;
  logic mode_gs;
  logic ext_mode;
  logic [STAT_W-1:0] status;
  modport core (input sr_data, seen_tgl, fall_tgl,
                output arm_tgl, half_sel, mode_gs, ext_mode, status);
  modport link (output sr_data, seen_tgl, fall_tgl,
                input arm_tgl, half_sel, mode_gs, ext_mode, status);
endinterface

// *** rtl/ledd_shift.sv ***
/*
  Shift clock domain: input shift register, status load and serial out.
  Assumes the controller keeps the shift clock still around latch strobes.
*/
`timescale 1ns/10ps
module ledd_shift
  import ledd_pkg::*;
(
  input wire logic i_shift_clock,
  input wire logic i_rstn,
  input wire logic i_serial_in,
  output logic o_serial_out,
  ledd_xfer_if.link x
);
  typedef struct packed {
    logic [GS_LEN-1:0] sr;
    logic seen;
  } ledd_link_s;

  ledd_link_s st_reg, st_next;
  logic fall_out_reg;
  logic fall_tgl_reg;
  logic first;
  logic load_ok;
  logic [7:0] top;

  // ----------------------------------------
  // Shift path
  // ----------------------------------------
  always_comb begin
    top = (x.mode_gs && !x.ext_mode) ? 8'(GS_LEN - 1) : 8'(HALF_LEN - 1); // RL14
    first = (st_reg.seen != x.arm_tgl);
    load_ok = first && x.mode_gs && (!x.ext_mode || x.half_sel); // RL1 RL21 RL22
  end

  always_comb begin
    st_next = st_reg;
    st_next.sr = {st_reg.sr[GS_LEN-2:0], i_serial_in}; // RL23
    if (load_ok) begin
      if (x.ext_mode) begin
        st_next.sr[HALF_LEN-1 -: STAT_W] = x.status; // RL21
      end else begin
        st_next.sr[GS_LEN-1 -: STAT_W] = x.status; // RL2
      end
    end
    if (first) begin
      st_next.seen = x.arm_tgl;
    end
  end

  always_ff @(posedge i_shift_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Falling edge stage buys the far device half a clock of hold
  always_ff @(negedge i_shift_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      fall_out_reg <= 1'b0;
      fall_tgl_reg <= 1'b0;
    end else begin
      fall_out_reg <= st_reg.sr[top]; // RL20
      fall_tgl_reg <= st_reg.seen; // RL8
    end
  end

  assign o_serial_out = x.ext_mode ? fall_out_reg : st_reg.sr[top]; // RL3 RL16 RL20
  assign x.sr_data = st_reg.sr;
  assign x.seen_tgl = st_reg.seen;
  assign x.fall_tgl = fall_tgl_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_shift_in;
    @(posedge i_shift_clock) disable iff (!i_rstn)
      1'b1 |=> ##1 st_reg.sr[1] == $past(i_serial_in, 2);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift order broken"); // RL23

  property p_status_load;
    @(posedge i_shift_clock) disable iff (!i_rstn)
      (load_ok && !x.ext_mode) |=> st_reg.sr[GS_LEN-1 -: STAT_W] == $past(x.status);
  endproperty
  a_status_load: assert property (p_status_load) else $error("status not loaded"); // RL2

  property p_trim_plain;
    @(posedge i_shift_clock) disable iff (!i_rstn)
      !x.mode_gs |=> st_reg.sr[GS_LEN-1:1] == $past(st_reg.sr[GS_LEN-2:0]);
  endproperty
  a_trim_plain: assert property (p_trim_plain) else $error("status in trim mode"); // RL1

  c_status_load: cover property (@(posedge i_shift_clock) disable iff (!i_rstn) load_ok);
endmodule // ledd_shift

// *** rtl/ledd_top.sv ***
/*
  LED sink driver control: latches, PWM counter, grouped outputs,
  open-LED and over-temperature flags, error pin, extended interface.
  Core runs on i_clock, which is the PWM count clock; the serial link
  runs on its own shift clock. The blank, latch, mode, select, sink-low and overtemp pins are synchronised by two flops.
*/
`timescale 1ns/10ps
module ledd_top
  import ledd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_shift_clock,
  input wire logic i_serial_in,
  input wire logic i_latch_strobe,
  input wire logic i_mode,
  input wire logic i_blank,
  input wire logic i_extended_iface_sel_n,
  input wire logic [NCH-1:0] i_sink_low,
  input wire logic i_overtemp_sense,
  output logic o_serial_out,
  output logic [NCH-1:0] o_sink_on,
  output logic [DC_LEN-1:0] o_current_trim,
  output logic o_error_flag_n_out,
  output logic o_error_flag_n_oe
);
  typedef struct packed {
    logic blank_s1;
    logic blank_s2;
    logic lat_s1;
    logic lat_s2;
    logic lat_d;
    logic mode_s1;
    logic mode_s2;
    logic ext_s1;
    logic ext_s2;
    logic [NCH-1:0] low_s1;
    logic [NCH-1:0] low_s2;
    logic ots_s1;
    logic ots_s2;
    logic seen_s1;
    logic seen_s2;
    logic fall_s1;
    logic fall_s2;
    logic fall_d;
    logic [11:0] cnt;
    logic [GS_LEN-1:0] gs;
    logic [DC_LEN-1:0] dc;
    logic [TAPS-1:0][NCH-1:0] line;
    logic [NCH-1:0] sink;
    logic [NCH-1:0] open_led_flag;
    logic overtemp_flag;
    logic arm;
    logic [1:0] sel_cnt;
    logic half;
    logic [STAT_W-1:0] status;
    logic err;
    logic drv;
  } ledd_core_s;

  ledd_core_s st_reg, st_next;
  logic [NCH-1:0] raw;
  logic [NCH-1:0] tap;
  logic lat_rise;
  logic fall_evt;
  logic shifted;
  logic gs_mode;
  logic ext_mode;

  ledd_xfer_if xf();

  ledd_shift u_shift (
    .i_shift_clock(i_shift_clock),
    .i_rstn(i_rstn),
    .i_serial_in(i_serial_in),
    .o_serial_out(o_serial_out),
    .x(xf)
  );

  // ----------------------------------------
  // Per channel compare and group taps
  // ----------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign raw[i] = !st_reg.blank_s2 && (st_reg.cnt != CNT_RST)
                    && (st_reg.cnt <= st_reg.gs[GS_W*i +: GS_W]); // RL24 RL13
    assign tap[i] = st_reg.line[(i % NGRP) * GRP_DLY][i]; // RL11 RL26
  end

  assign lat_rise = st_reg.lat_s2 && !st_reg.lat_d;
  assign fall_evt = st_reg.fall_s2 != st_reg.fall_d;
  // Equal toggles mean the link took at least one edge since the last latch
  assign shifted = st_reg.seen_s2 == st_reg.arm;
  assign gs_mode = !st_reg.mode_s2;
  assign ext_mode = gs_mode && !st_reg.ext_s2; // RL22

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.blank_s1 = i_blank;
    st_next.blank_s2 = st_reg.blank_s1;
    st_next.lat_s1 = i_latch_strobe;
    st_next.lat_s2 = st_reg.lat_s1;
    st_next.lat_d = st_reg.lat_s2;
    st_next.mode_s1 = i_mode;
    st_next.mode_s2 = st_reg.mode_s1;
    st_next.ext_s1 = i_extended_iface_sel_n;
    st_next.ext_s2 = st_reg.ext_s1;
    st_next.low_s1 = i_sink_low;
    st_next.low_s2 = st_reg.low_s1;
    st_next.ots_s1 = i_overtemp_sense;
    st_next.ots_s2 = st_reg.ots_s1;
    st_next.seen_s1 = xf.seen_tgl;
    st_next.seen_s2 = st_reg.seen_s1;
    st_next.fall_s1 = xf.fall_tgl;
    st_next.fall_s2 = st_reg.fall_s1;
    st_next.fall_d = st_reg.fall_s2;
    st_next.drv = 1'b0; // RL10

    if (st_reg.blank_s2) begin
      st_next.cnt = CNT_RST; // RL12
    end else if (st_reg.cnt != CNT_MAX) begin
      st_next.cnt = st_reg.cnt + 12'h001; // RL24
    end

    st_next.line = {st_reg.line[TAPS-2:0], raw};
    // Blank cuts every group at once, delayed groups included
    st_next.sink = tap & ~{NCH{st_reg.blank_s2}}; // RL12 RL13

    if (!st_reg.blank_s2 && st_reg.cnt == LOD_EDGE - 12'h001) begin
      st_next.open_led_flag = st_reg.sink & st_reg.low_s2; // RL4 RL5
    end

    // A fresh over-temperature reading wins over the clear
    st_next.overtemp_flag = st_reg.ots_s2 | (st_reg.overtemp_flag & ~fall_evt); // RL7 RL8

    st_next.err = st_next.overtemp_flag
                  | ((|st_next.open_led_flag) & ~st_reg.blank_s2); // RL9

    if (lat_rise) begin
      // Arm against what the link last saw, so strobes with no shift between still arm
      st_next.arm = !st_reg.seen_s2; // RL2
      st_next.status = {st_reg.overtemp_flag, st_reg.open_led_flag}; // RL25
      if (!gs_mode) begin
        st_next.dc = xf.sr_data[DC_LEN-1:0]; // RL14 RL23
      end else if (!ext_mode) begin
        st_next.gs = xf.sr_data; // RL14 RL23
      end else if (st_reg.blank_s2 && !shifted) begin
        if (st_reg.sel_cnt != SEL_HIGH) begin
          st_next.sel_cnt = st_reg.sel_cnt + 2'h1; // RL18
        end
        st_next.half = (st_reg.sel_cnt != SEL_RST); // RL18
      end else begin
        if (st_reg.half) begin
          st_next.gs[GS_LEN-1 -: HALF_LEN] = xf.sr_data[HALF_LEN-1:0];
        end else begin
          st_next.gs[HALF_LEN-1:0] = xf.sr_data[HALF_LEN-1:0];
        end
        st_next.sel_cnt = SEL_RST;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs and link words
  // ----------------------------------------
  assign o_sink_on = st_reg.sink;
  assign o_current_trim = st_reg.dc;
  assign o_error_flag_n_out = st_reg.drv;
  assign o_error_flag_n_oe = st_reg.err; // RL9 RL10
  assign xf.arm_tgl = st_reg.arm;
  assign xf.half_sel = st_reg.half;
  assign xf.mode_gs = gs_mode;
  assign xf.ext_mode = ext_mode;
  assign xf.status = st_reg.status;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_blank_off;
    @(posedge i_clock) disable iff (!i_rstn)
      st_reg.blank_s2 |=> (o_sink_on == '0) && (st_reg.cnt == CNT_RST);
  endproperty
  a_blank_off: assert property (p_blank_off) else $error("outputs on under blank"); // RL12

  property p_cnt_stop;
    @(posedge i_clock) disable iff (!i_rstn)
      (st_reg.cnt == CNT_MAX && !st_reg.blank_s2) |=> st_reg.cnt == CNT_MAX;
  endproperty
  a_cnt_stop: assert property (p_cnt_stop) else $error("counter passed top"); // RL24

  property p_cnt_step;
    @(posedge i_clock) disable iff (!i_rstn)
      (!st_reg.blank_s2 && st_reg.cnt != CNT_MAX) |=> st_reg.cnt == $past(st_reg.cnt) + 12'h001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter missed a step"); // RL24

  property p_lod_hold;
    @(posedge i_clock) disable iff (!i_rstn)
      (st_reg.blank_s2 || st_reg.cnt != LOD_EDGE - 12'h001) |=> $stable(st_reg.open_led_flag);
  endproperty
  a_lod_hold: assert property (p_lod_hold) else $error("open flags moved"); // RL4

  property p_lod_set;
    @(posedge i_clock) disable iff (!i_rstn)
      (!st_reg.blank_s2 && st_reg.cnt == LOD_EDGE - 12'h001)
        |=> st_reg.open_led_flag == ($past(st_reg.sink) & $past(st_reg.low_s2));
  endproperty
  a_lod_set: assert property (p_lod_set) else $error("open flags wrong"); // RL5

  property p_ot_set;
    @(posedge i_clock) disable iff (!i_rstn)
      st_reg.ots_s1 |=> ##1 st_reg.overtemp_flag && o_error_flag_n_oe;
  endproperty
  a_ot_set: assert property (p_ot_set) else $error("overtemp not raised"); // RL7

  property p_ot_keep;
    @(posedge i_clock) disable iff (!i_rstn)
      (st_reg.overtemp_flag && !fall_evt) |=> st_reg.overtemp_flag;
  endproperty
  a_ot_keep: assert property (p_ot_keep) else $error("overtemp cleared early"); // RL8

  property p_err_mask;
    @(posedge i_clock) disable iff (!i_rstn)
      (st_reg.blank_s2 && !st_next.overtemp_flag) |=> !o_error_flag_n_oe;
  endproperty
  a_err_mask: assert property (p_err_mask) else $error("blank did not mask"); // RL9

  property p_od;
    @(posedge i_clock) disable iff (!i_rstn)
      o_error_flag_n_oe |-> !o_error_flag_n_out;
  endproperty
  a_od: assert property (p_od) else $error("error pin drove high"); // RL10

  property p_trim_latch;
    @(posedge i_clock) disable iff (!i_rstn)
      (lat_rise && !gs_mode) |=> o_current_trim == $past(xf.sr_data[DC_LEN-1:0]);
  endproperty
  a_trim_latch: assert property (p_trim_latch) else $error("trim latch wrong"); // RL23

  property p_half_sel;
    @(posedge i_clock) disable iff (!i_rstn)
      (lat_rise && ext_mode && st_reg.blank_s2 && !shifted && st_reg.sel_cnt == 2'h1)
        |=> st_reg.half;
  endproperty
  a_half_sel: assert property (p_half_sel) else $error("upper half not chosen"); // RL18

  c_lod: cover property (@(posedge i_clock) disable iff (!i_rstn)
    !st_reg.blank_s2 && st_reg.cnt == LOD_EDGE - 12'h001);
  c_half: cover property (@(posedge i_clock) disable iff (!i_rstn) $rose(st_reg.half));
  c_ot_clr: cover property (@(posedge i_clock) disable iff (!i_rstn) $fell(st_reg.overtemp_flag));
endmodule // ledd_top

// *** verification/ledd_led_model.sv ***
/*
  LED string and shared error wire seen from the driver pins.
  Assumes sink outputs are active high and oe high pulls the wire low.
*/
`timescale 1ns/10ps
module ledd_led_model
  import ledd_pkg::*;
(
  input wire logic [NCH-1:0] i_sink_on,
  input wire logic [NCH-1:0] i_open_mask,
  input wire logic i_err_out,
  input wire logic i_err_oe,
  output logic [NCH-1:0] o_sink_low,
  output logic o_err_wire
);
  // ----------------------------------------
  // Load and wire
  // ----------------------------------------
  // Open string collapses the sink only while driven
  assign o_sink_low = i_sink_on & i_open_mask;
  // Pull-up wins whenever nobody pulls
  assign o_err_wire = i_err_oe ? i_err_out : 1'b1;
endmodule // ledd_led_model

// *** verification/test_led_driver_status_serial_ctrl.sv ***
/*
  Self-checking bench for the LED driver control: trim and grayscale
  loading, PWM stagger, open-LED and over-temperature flags, readback.
  Assumes the shift clock is made here and stays still around latches.
*/
`timescale 1ns/10ps
module test_led_driver_status_serial_ctrl
  import ledd_pkg::*;
;
  logic clk, rstn, sclk, serial_in, lat, mode, blank, ext_n, ots, serial_out, eo, eoe, err_wire;
  logic [NCH-1:0] sink_low, sink_on, open_mask;
  logic [DC_LEN-1:0] trim;
  int num_errors, n_tests;

  ledd_top u_ledd_top (.i_clock(clk), .i_rstn(rstn), .i_shift_clock(sclk),
    .i_serial_in(serial_in), .i_latch_strobe(lat), .i_mode(mode), .i_blank(blank),
    .i_extended_iface_sel_n(ext_n), .i_sink_low(sink_low), .i_overtemp_sense(ots),
    .o_serial_out(serial_out), .o_sink_on(sink_on), .o_current_trim(trim),
    .o_error_flag_n_out(eo), .o_error_flag_n_oe(eoe));
  ledd_led_model u_ledd_led_model (.i_sink_on(sink_on), .i_open_mask(open_mask),
    .i_err_out(eo), .i_err_oe(eoe), .o_sink_low(sink_low), .o_err_wire(err_wire));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One shift period, output sampled after the rising edge
  task automatic sbit(input logic b, output logic o);
    serial_in = b;
    #80 sclk = 1'b1;
    #20 o = serial_out;
    #60 sclk = 1'b0;
  endtask

  // Quiet shift clock on both sides, strobe long enough for the sync
  task automatic latch();
    cyc(5);
    lat = 1'b1;
    cyc(3);
    lat = 1'b0;
    cyc(5);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_trim();
    logic o;
    logic [95:0] pat;
    pat = 96'h0123_4567_89ab_cdef_fedc_ba98;
    mode = 1'b1;
    ext_n = 1'b0;
    for (int i = 95; i >= 0; i--) sbit(pat[i], o);
    latch();
    check(trim, pat);
    mode = 1'b0;
    ext_n = 1'b1;
  endtask

  task automatic t_gs();
    logic o;
    logic [11:0] gs [NCH];
    int first [NCH];
    int cnt [NCH];
    for (int n = 0; n < NCH; n++) begin
      gs[n] = 12'h022 + 12'(n);
      first[n] = -1;
      cnt[n] = 0;
    end
    for (int n = NCH - 1; n >= 0; n--)
      for (int b = 11; b >= 0; b--) sbit(gs[n][b], o);
    latch();
    open_mask = 16'h0020;
    blank = 1'b0;
    for (int c = 0; c < 80; c++) begin
      @(negedge clk);
      if (c == 20) check(96'(err_wire), 96'h1);
      for (int n = 0; n < NCH; n++) begin
        if (sink_on[n]) begin
          cnt[n]++;
          if (first[n] < 0) first[n] = c;
        end
      end
    end
    check(96'(err_wire), 96'h0);
    blank = 1'b1;
    cyc(4);
    check(96'(sink_on), 96'h0);
    check(96'(err_wire), 96'h1);
    for (int n = 0; n < NCH; n++) begin
      check(96'(cnt[n]), 96'(gs[n]));
      check(96'(first[n] - first[0]), 96'((n % NGRP) * GRP_DLY));
    end
  endtask

  // Overtemp first, then channel 15 down to 0
  task automatic t_read(input logic ot);
    logic o;
    logic [16:0] w;
    latch();
    for (int i = 16; i >= 0; i--) begin
      sbit(1'b0, o);
      w[i] = o;
    end
    check(96'(w), 96'({ot, 16'h0020}));
  endtask

  task automatic t_ot();
    ots = 1'b1;
    cyc(5);
    check(96'(err_wire), 96'h0);
    ots = 1'b0;
    cyc(10);
    check(96'(err_wire), 96'h0);
    t_read(1'b1);
    cyc(6);
    check(96'(err_wire), 96'h1);
  endtask

  // Extended link: status leads the upper half only, out on falling edges
  task automatic t_ext();
    logic o;
    logic [16:0] w;
    ext_n = 1'b0;
    // First strobe closes the last normal frame as a write
    latch();
    latch();
    latch();
    for (int j = 0; j < 96; j++) begin
      sbit(1'b1, o);
      if (j > 0 && j < 18) w[17-j] = o;
    end
    check(96'(w), 96'({1'b0, 16'h0020}));
    latch();
    latch();
    for (int j = 0; j < 18; j++) begin
      sbit(1'b0, o);
      if (j > 0) w[17-j] = o;
    end
    check(96'(w), 96'h1ffff);
    ext_n = 1'b1;
  endtask

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #400us;
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    num_errors = 0;
    n_tests = 0;
    rstn = 1'b0;
    sclk = 1'b0;
    serial_in = 1'b0;
    lat = 1'b0;
    mode = 1'b0;
    blank = 1'b1;
    ext_n = 1'b1;
    ots = 1'b0;
    open_mask = '0;
    cyc(12);
    rstn = 1'b1;
    cyc(3);
    check(96'(sink_on), 96'h0);
    check(96'(err_wire), 96'h1);
    t_trim();
    t_gs();
    t_read(1'b0);
    t_ot();
    t_ext();
    wrap_up();
  end
endmodule // test_led_driver_status_serial_ctrl
